// ==== include/srs_pkg.sv ====
// Shared constants and types of the shutter readout sequencer.
package srs_pkg;
	// Parallel configuration word: address in the top nibble, data below.
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 12;
	localparam int DATA_W = 12;
	localparam int WORD_W = 16;
	localparam int PTR_W = 11;
	localparam int LINE_W = 12;

	// Register addresses.
	localparam logic [3:0] ADDR_SEQUENCER = 4'h0;
	localparam logic [3:0] ADDR_PIXEL_COUNT_LIMIT = 4'h1;
	localparam logic [3:0] ADDR_LINE_COUNT_LIMIT = 4'h2;
	localparam logic [3:0] ADDR_INTEGRATION_TIME = 4'h3;
	localparam logic [3:0] ADDR_COLUMN_START = 4'h4;
	localparam logic [3:0] ADDR_ROW_START_READ = 4'h5;
	localparam logic [3:0] ADDR_ROW_START_RESET = 4'h6;
	localparam logic [3:0] ADDR_CORE_TEST_SUBSAMPLE = 4'h7;

	// Reset values.
	localparam logic [11:0] RST_SEQUENCER = 12'h000;
	localparam logic [11:0] RST_PIXEL_COUNT_LIMIT = 12'h27f;
	localparam logic [11:0] RST_LINE_COUNT_LIMIT = 12'h3ff;
	localparam logic [11:0] RST_INTEGRATION_TIME = 12'h7ff;
	localparam logic [10:0] RST_COLUMN_START = 11'h000;
	localparam logic [10:0] RST_ROW_START = 11'h000;
	localparam logic [7:0] RST_CORE_TEST_SUBSAMPLE = 8'h00;

	// Sequencer register fields.
	localparam int SEQ_SHUTTER_BIT = 0;
	localparam int SEQ_GRAN_X_LSB = 4;
	localparam int SEQ_GRAN_SS_LSB = 6;
	localparam int SEQ_KNEE_LSB = 8;
	localparam int SEQ_KNEE_ENABLE_BIT = 10;
	localparam int SEQ_EXT_RESET_BIT = 11;

	// Core test and sub-sampling fields.
	localparam int CORE_TEST_EVEN_BIT = 0;
	localparam int CORE_TEST_ODD_BIT = 1;
	localparam int CORE_HSUB_LSB = 2;
	localparam int CORE_VSUB_LSB = 5;
	localparam logic [7:0] CORE_PAIRWISE_TEST = 8'h09;

	// Reset level drop per knee selection, in millivolts.
	localparam logic [11:0] KNEE_DROP_MV_1 = 12'd760;
	localparam logic [11:0] KNEE_DROP_MV_2 = 12'd1520;
	localparam logic [11:0] KNEE_DROP_MV_3 = 12'd2280;

	// Timing: granularities are in system clock cycles.
	localparam int CLOCK_PERIOD_NS = 100;
	localparam logic [8:0] SS_GRAN_BASE = 9'd32;
	localparam logic [10:0] X_GRAN_BASE = 11'd4;
	localparam logic [10:0] ROW_BLANK_UNITS = 11'd35;

	// Test pattern codes.
	localparam logic [1:0] PATTERN_NONE = 2'h0;
	localparam logic [1:0] PATTERN_ALTERNATE = 2'h1;
	localparam logic [1:0] PATTERN_PAIRWISE = 2'h2;

	typedef enum logic [1:0] {SS_IDLE, SS_INTEGRATE, SS_TIMEOUT} srs_ss_state_t;
	typedef enum logic [1:0] {ROW_IDLE, ROW_HOLD, ROW_BLANK, ROW_READ} srs_row_state_t;

	// One readout pixel pair address.
	typedef struct packed {
		logic [10:0] row;
		logic [10:0] column;
	} srs_pixel_t;
endpackage

// ==== design/srs_fifo.sv ====
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module srs_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign o_in_ready = count_reg != (AW+1)'(DEPTH);
	assign o_out_valid = count_reg != '0;
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // srs_fifo

// ==== design/srs_sequencer.sv ====
// Readout and shutter sequencer with configuration registers and pixel FIFO.
//
// How it works
// - Knee selection picks right reset level drop.
// - Single slope resets from left supply.
// - Knee enable moves reset control right.
// - External bit disables generator, else monitorable.
// - Pixel valid rises at row readout sync.
// - Pixel valid falls at pixel count limit.
// - Line counter counts rows, pulses last line.
// - Synchronous timer counts granulated cycles to timeout.
// - Frame start loads read pointer in rolling.
// - Row clock advances pointer; match loads reset pointer.
// - Read pointer sync clears integration counter.
// - Rolling exposure is line limit minus integration.
// - Row start registers give read and reset starts.
// - Core bits 1:0 tie odd or even columns.
// - Settings 1, 2 alternate; 9 gives pairwise pattern.
// - Core bits select horizontal and vertical sub-sampling.
// - Sequencer bit 0 selects rolling shutter.
`timescale 1ns/1ps
module srs_sequencer #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Parallel configuration pins
	input wire logic [15:0] i_config_data,
	input wire logic i_config_write,
	// Controller strobes
	input wire logic i_frame_start,
	input wire logic i_row_clock,
	input wire logic i_shutter_start,
	input wire logic i_shutter_stop,
	// Readout status
	output logic o_pixel_valid,
	output logic o_last_line,
	output logic o_timeout,
	// Pixel address stream
	output logic o_pixel_out_valid,
	input wire logic i_pixel_out_ready,
	output srs_pkg::srs_pixel_t o_pixel_out,
	// Rolling shutter pointers
	output logic o_read_pointer_sync,
	output logic o_reset_pointer_sync,
	output logic [10:0] o_read_row_pointer,
	output logic [10:0] o_reset_row_pointer,
	output logic [11:0] o_rolling_exposure_lines,
	// Reset voltage control
	output logic o_reset_from_right,
	output logic [1:0] o_knee_select,
	output logic [11:0] o_right_reset_drop_mv,
	output logic o_reset_generator_enable,
	output logic o_right_reset_monitor,
	// Image core control
	output logic o_rolling_shutter,
	output logic o_tie_odd_columns,
	output logic o_tie_even_columns,
	output logic [1:0] o_test_pattern,
	output logic [2:0] o_hsub_mode,
	output logic [2:0] o_vsub_mode
);
	// Pin synchronisers: stage one feeds only stage two.
	logic [19:0] pins_s1_reg;
	logic [19:0] pins_s2_reg;
	logic [4:0] strobe_prev_reg;
	logic [15:0] cfg_word;
	logic cfg_wr_edge;
	logic frame_edge;
	logic row_rise;
	logic row_fall;
	logic ss_start_fall;
	logic ss_stop_level;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pins_s1_reg <= '0;
			pins_s2_reg <= '0;
			strobe_prev_reg <= '0;
		end else begin
			pins_s1_reg <= {i_config_write, i_frame_start, i_row_clock, i_shutter_start, i_config_data};
			pins_s2_reg <= pins_s1_reg;
			strobe_prev_reg <= {pins_s2_reg[19:16], 1'b0};
		end
	end

	assign cfg_word = pins_s2_reg[15:0];
	assign cfg_wr_edge = pins_s2_reg[19] & ~strobe_prev_reg[4];
	assign frame_edge = pins_s2_reg[18] & ~strobe_prev_reg[3];
	assign row_rise = pins_s2_reg[17] & ~strobe_prev_reg[2];
	assign row_fall = ~pins_s2_reg[17] & strobe_prev_reg[2];
	assign ss_start_fall = ~pins_s2_reg[16] & strobe_prev_reg[1];

	logic stop_s1_reg;
	logic stop_s2_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			stop_s1_reg <= 1'b0;
			stop_s2_reg <= 1'b0;
		end else begin
			stop_s1_reg <= i_shutter_stop;
			stop_s2_reg <= stop_s1_reg;
		end
	end

	assign ss_stop_level = stop_s2_reg;

	// Configuration registers, written from the parallel word.
	logic [11:0] sequencer_reg;
	logic [11:0] pixel_count_limit_reg;
	logic [11:0] line_count_limit_reg;
	logic [11:0] integration_time_reg;
	logic [10:0] column_start_reg;
	logic [10:0] row_start_read_reg;
	logic [10:0] row_start_reset_reg;
	logic [7:0] core_test_subsample_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sequencer_reg <= srs_pkg::RST_SEQUENCER;
			pixel_count_limit_reg <= srs_pkg::RST_PIXEL_COUNT_LIMIT;
			line_count_limit_reg <= srs_pkg::RST_LINE_COUNT_LIMIT;
			integration_time_reg <= srs_pkg::RST_INTEGRATION_TIME;
			column_start_reg <= srs_pkg::RST_COLUMN_START;
			row_start_read_reg <= srs_pkg::RST_ROW_START;
			row_start_reset_reg <= srs_pkg::RST_ROW_START;
			core_test_subsample_reg <= srs_pkg::RST_CORE_TEST_SUBSAMPLE;
		end else if (cfg_wr_edge) begin
			case (cfg_word[srs_pkg::ADDR_MSB:srs_pkg::ADDR_LSB])
				srs_pkg::ADDR_SEQUENCER: sequencer_reg <= cfg_word[11:0];
				srs_pkg::ADDR_PIXEL_COUNT_LIMIT: pixel_count_limit_reg <= cfg_word[11:0];
				srs_pkg::ADDR_LINE_COUNT_LIMIT: line_count_limit_reg <= cfg_word[11:0];
				srs_pkg::ADDR_INTEGRATION_TIME: integration_time_reg <= cfg_word[11:0];
				srs_pkg::ADDR_COLUMN_START: column_start_reg <= cfg_word[10:0];
				srs_pkg::ADDR_ROW_START_READ: row_start_read_reg <= cfg_word[10:0];
				srs_pkg::ADDR_ROW_START_RESET: row_start_reset_reg <= cfg_word[10:0];
				srs_pkg::ADDR_CORE_TEST_SUBSAMPLE: core_test_subsample_reg <= cfg_word[7:0];
				default: begin
				end
			endcase
		end
	end

	// Static control decoded straight from the registers.
	logic rolling;
	logic knee_enable;
	logic [1:0] knee_sel;

	assign rolling = sequencer_reg[srs_pkg::SEQ_SHUTTER_BIT];
	assign knee_enable = sequencer_reg[srs_pkg::SEQ_KNEE_ENABLE_BIT];
	assign knee_sel = sequencer_reg[srs_pkg::SEQ_KNEE_LSB +: 2];
	assign o_rolling_shutter = rolling;
	// Single slope keeps the left side in charge; the knee bit hands it to the right.
	assign o_reset_from_right = knee_enable;
	assign o_knee_select = knee_sel;
	assign o_reset_generator_enable = ~sequencer_reg[srs_pkg::SEQ_EXT_RESET_BIT];
	assign o_right_reset_monitor = ~sequencer_reg[srs_pkg::SEQ_EXT_RESET_BIT];
	assign o_tie_even_columns = core_test_subsample_reg[srs_pkg::CORE_TEST_EVEN_BIT];
	assign o_tie_odd_columns = core_test_subsample_reg[srs_pkg::CORE_TEST_ODD_BIT];
	assign o_hsub_mode = core_test_subsample_reg[srs_pkg::CORE_HSUB_LSB +: 3];
	assign o_vsub_mode = core_test_subsample_reg[srs_pkg::CORE_VSUB_LSB +: 3];

	always_comb begin
		case (knee_sel)
			2'h1: o_right_reset_drop_mv = srs_pkg::KNEE_DROP_MV_1;
			2'h2: o_right_reset_drop_mv = srs_pkg::KNEE_DROP_MV_2;
			2'h3: o_right_reset_drop_mv = srs_pkg::KNEE_DROP_MV_3;
			default: o_right_reset_drop_mv = '0;
		endcase
	end

	always_comb begin
		case (core_test_subsample_reg)
			8'h01, 8'h02: o_test_pattern = srs_pkg::PATTERN_ALTERNATE;
			srs_pkg::CORE_PAIRWISE_TEST: o_test_pattern = srs_pkg::PATTERN_PAIRWISE;
			default: o_test_pattern = srs_pkg::PATTERN_NONE;
		endcase
	end

	// Row readout: blanking after the row clock, then one pixel pair per push.
	srs_pkg::srs_row_state_t row_state_reg;
	logic [10:0] blank_cnt_reg;
	logic [10:0] blank_len;
	logic [11:0] pixel_cnt_reg;
	logic pixel_valid_reg;
	logic x_sync;
	logic fifo_in_ready;
	logic push;
	srs_pkg::srs_pixel_t pixel_word;

	assign blank_len = 11'(srs_pkg::ROW_BLANK_UNITS * (srs_pkg::X_GRAN_BASE << sequencer_reg[srs_pkg::SEQ_GRAN_X_LSB +: 2]));
	assign x_sync = (row_state_reg == srs_pkg::ROW_BLANK) && (blank_cnt_reg == blank_len - 11'd1);
	// A full FIFO stalls the pixel counter, so no address is ever dropped.
	assign push = pixel_valid_reg & fifo_in_ready;
	assign pixel_word.row = o_read_row_pointer;
	assign pixel_word.column = 11'(column_start_reg + pixel_cnt_reg[10:0]);
	assign o_pixel_valid = pixel_valid_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			row_state_reg <= srs_pkg::ROW_IDLE;
			blank_cnt_reg <= '0;
		end else begin
			case (row_state_reg)
				srs_pkg::ROW_IDLE: begin
					if (row_rise) begin
						row_state_reg <= srs_pkg::ROW_HOLD;
					end
				end
				srs_pkg::ROW_HOLD: begin
					blank_cnt_reg <= '0;
					if (row_fall) begin
						row_state_reg <= srs_pkg::ROW_BLANK;
					end
				end
				srs_pkg::ROW_BLANK: begin
					blank_cnt_reg <= blank_cnt_reg + 11'd1;
					if (x_sync) begin
						row_state_reg <= srs_pkg::ROW_READ;
					end
				end
				srs_pkg::ROW_READ: begin
					if (push && pixel_cnt_reg == pixel_count_limit_reg) begin
						row_state_reg <= srs_pkg::ROW_IDLE;
					end
				end
				default: row_state_reg <= srs_pkg::ROW_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pixel_valid_reg <= 1'b0;
			pixel_cnt_reg <= '0;
		end else if (x_sync) begin
			pixel_valid_reg <= 1'b1;
			pixel_cnt_reg <= '0;
		end else if (push) begin
			pixel_cnt_reg <= pixel_cnt_reg + 12'd1;
			if (pixel_cnt_reg == pixel_count_limit_reg) begin
				pixel_valid_reg <= 1'b0;
			end
		end
	end

	a_valid_rise: assert property (@(posedge i_clock) disable iff (!i_rstn)
		x_sync |=> o_pixel_valid && pixel_cnt_reg == 12'd0) else $error("pixel valid did not rise at row sync");
	a_valid_fall: assert property (@(posedge i_clock) disable iff (!i_rstn)
		push && pixel_cnt_reg == pixel_count_limit_reg |=> !o_pixel_valid) else $error("pixel valid did not fall");

	srs_fifo #(
		.WIDTH($bits(srs_pkg::srs_pixel_t)),
		.DEPTH(FIFO_DEPTH)
	) i_srs_fifo (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_in_valid(pixel_valid_reg),
		.o_in_ready(fifo_in_ready),
		.i_in_data(pixel_word),
		.o_out_valid(o_pixel_out_valid),
		.i_out_ready(i_pixel_out_ready),
		.o_out_data(o_pixel_out)
	);

	// Line counter and last line pulse.
	logic [11:0] line_cnt_reg;
	logic last_line_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			line_cnt_reg <= '0;
			last_line_reg <= 1'b0;
		end else begin
			last_line_reg <= 1'b0;
			if (frame_edge) begin
				line_cnt_reg <= '0;
			end else if (row_rise) begin
				line_cnt_reg <= line_cnt_reg + 12'd1;
				last_line_reg <= (line_cnt_reg + 12'd1) == line_count_limit_reg;
			end
		end
	end

	assign o_last_line = last_line_reg;

	a_last_line: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!frame_edge && row_rise && (line_cnt_reg + 12'd1) == line_count_limit_reg
		|=> o_last_line ##1 !o_last_line) else $error("last line pulse wrong");

	// Synchronous shutter integration timer on the granulated clock.
	srs_pkg::srs_ss_state_t ss_state_reg;
	logic [8:0] gran_cnt_reg;
	logic [8:0] gran_len;
	logic gran_tick;
	logic [11:0] ss_cnt_reg;
	logic timeout_reg;

	assign gran_len = srs_pkg::SS_GRAN_BASE << sequencer_reg[srs_pkg::SEQ_GRAN_SS_LSB +: 2];
	assign gran_tick = gran_cnt_reg == gran_len - 9'd1;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			gran_cnt_reg <= '0;
		end else if (ss_start_fall || gran_tick) begin
			gran_cnt_reg <= '0;
		end else begin
			gran_cnt_reg <= gran_cnt_reg + 9'd1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ss_state_reg <= srs_pkg::SS_IDLE;
			ss_cnt_reg <= '0;
			timeout_reg <= 1'b0;
		end else begin
			case (ss_state_reg)
				srs_pkg::SS_IDLE: begin
					if (ss_start_fall && !rolling) begin
						ss_state_reg <= srs_pkg::SS_INTEGRATE;
						ss_cnt_reg <= '0;
					end
				end
				srs_pkg::SS_INTEGRATE: begin
					// An early stop from an external counter ends integration at once.
					if (ss_stop_level) begin
						ss_state_reg <= srs_pkg::SS_IDLE;
					end else if (gran_tick) begin
						ss_cnt_reg <= ss_cnt_reg + 12'd1;
						if ((ss_cnt_reg + 12'd1) == integration_time_reg) begin
							ss_state_reg <= srs_pkg::SS_TIMEOUT;
							timeout_reg <= 1'b1;
						end
					end
				end
				srs_pkg::SS_TIMEOUT: begin
					if (gran_tick) begin
						ss_state_reg <= srs_pkg::SS_IDLE;
						timeout_reg <= 1'b0;
					end
				end
				default: ss_state_reg <= srs_pkg::SS_IDLE;
			endcase
		end
	end

	assign o_timeout = timeout_reg;

	a_timeout_count: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(o_timeout) |-> ss_cnt_reg == integration_time_reg && gran_cnt_reg == 9'd0) else $error("timeout early");

	// Rolling shutter pointers and integration counter.
	logic [11:0] integ_cnt_reg;
	logic [10:0] read_ptr_reg;
	logic [10:0] reset_ptr_reg;
	logic read_sync_reg;
	logic reset_sync_reg;
	logic [11:0] exposure_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			integ_cnt_reg <= '0;
			read_ptr_reg <= '0;
			reset_ptr_reg <= '0;
			read_sync_reg <= 1'b0;
			reset_sync_reg <= 1'b0;
		end else begin
			read_sync_reg <= 1'b0;
			reset_sync_reg <= 1'b0;
			if (rolling && frame_edge) begin
				read_sync_reg <= 1'b1;
				read_ptr_reg <= row_start_read_reg;
				integ_cnt_reg <= '0;
			end else if (rolling && row_rise) begin
				read_ptr_reg <= read_ptr_reg + 11'd1;
				integ_cnt_reg <= integ_cnt_reg + 12'd1;
				if ((integ_cnt_reg + 12'd1) == integration_time_reg) begin
					reset_sync_reg <= 1'b1;
					reset_ptr_reg <= row_start_reset_reg;
				end else begin
					reset_ptr_reg <= reset_ptr_reg + 11'd1;
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			exposure_reg <= '0;
		end else begin
			exposure_reg <= line_count_limit_reg - integration_time_reg;
		end
	end

	assign o_read_pointer_sync = read_sync_reg;
	assign o_reset_pointer_sync = reset_sync_reg;
	assign o_read_row_pointer = read_ptr_reg;
	assign o_reset_row_pointer = reset_ptr_reg;
	assign o_rolling_exposure_lines = exposure_reg;

	a_read_sync: assert property (@(posedge i_clock) disable iff (!i_rstn)
		rolling && frame_edge |=> o_read_pointer_sync && o_read_row_pointer == $past(row_start_read_reg))
		else $error("read pointer not loaded");
	a_reset_sync: assert property (@(posedge i_clock) disable iff (!i_rstn)
		rolling && !frame_edge && row_rise && (integ_cnt_reg + 12'd1) == integration_time_reg
		|=> o_reset_pointer_sync && o_reset_row_pointer == $past(row_start_reset_reg))
		else $error("reset pointer not loaded");
	a_integ_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_read_pointer_sync |-> integ_cnt_reg == 12'd0) else $error("integration counter not cleared");
	a_reset_side: assert property (@(posedge i_clock) disable iff (!i_rstn)
		cfg_wr_edge && cfg_word[srs_pkg::ADDR_MSB:srs_pkg::ADDR_LSB] == srs_pkg::ADDR_SEQUENCER |=>
		o_reset_from_right == $past(cfg_word[srs_pkg::SEQ_KNEE_ENABLE_BIT])
		&& o_reset_generator_enable != $past(cfg_word[srs_pkg::SEQ_EXT_RESET_BIT])) else $error("reset side wrong");
endmodule // srs_sequencer

// ==== bench/srs_ctrl_model.sv ====
// Controller model that drives the sequencer strobes and drains the pixel stream.
`timescale 1ns/1ps
module srs_ctrl_model (
	// Clock
	input wire logic i_clock,
	// Strobes to the sequencer
	output logic o_frame_start,
	output logic o_row_clock,
	output logic o_shutter_start,
	output logic o_shutter_stop,
	// Drain side and status
	output logic o_ready,
	input wire logic i_timeout
);
	logic stall = 1'b0;
	logic abort = 1'b0;
	initial begin
		o_frame_start = 1'b0;
		o_row_clock = 1'b0;
		o_shutter_start = 1'b0;
		o_shutter_stop = 1'b0;
		o_ready = 1'b1;
	end
	// Strobe select: 0 frame start, 1 row clock, 2 shutter start.
	task automatic pulse(input int sel, input int len);
		@(posedge i_clock);
		case (sel)
			0: o_frame_start <= 1'b1;
			1: o_row_clock <= 1'b1;
			default: o_shutter_start <= 1'b1;
		endcase
		repeat (len) @(posedge i_clock);
		o_frame_start <= 1'b0;
		o_row_clock <= 1'b0;
		o_shutter_start <= 1'b0;
	endtask
	// Stop follows the timeout, which leaves an exposure at the programmed length, or abort, which ends it early.
	always @(posedge i_clock) begin
		o_shutter_stop <= i_timeout | abort;
		o_ready <= ~stall;
	end
endmodule // srs_ctrl_model

// ==== bench/srs_sequencer_tb.sv ====
// Self-checking bench for the shutter readout sequencer.
`timescale 1ns/1ps
module srs_sequencer_tb;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic [15:0] cfg = 16'h0000;
	logic cfg_wr = 1'b0;
	logic fs, rc, ss, sp, rdy, pv, ll, to, ov, rps, xps, rfr, gen, mon, rol, todd, tev;
	srs_pkg::srs_pixel_t pix;
	logic [10:0] rptr, xptr;
	logic [11:0] expo, drop;
	logic [1:0] ksel, pat;
	logic [2:0] hs, vs;
	logic [7:0] cv [5] = '{8'h01, 8'h02, 8'h09, 8'h8e, 8'h00};
	logic [11:0] dmv [4] = '{12'h000, 12'h2f8, 12'h5f0, 12'h8e8};
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_last = 0;
	int n_rs = 0;
	int n_xs = 0;
	int n, cnt, b;
	srs_sequencer i_srs_sequencer (.i_clock(i_clock), .i_rstn(i_rstn), .i_config_data(cfg),
		.i_config_write(cfg_wr), .i_frame_start(fs), .i_row_clock(rc), .i_shutter_start(ss),
		.i_shutter_stop(sp), .o_pixel_valid(pv), .o_last_line(ll), .o_timeout(to),
		.o_pixel_out_valid(ov), .i_pixel_out_ready(rdy), .o_pixel_out(pix), .o_read_pointer_sync(rps),
		.o_reset_pointer_sync(xps), .o_read_row_pointer(rptr), .o_reset_row_pointer(xptr),
		.o_rolling_exposure_lines(expo), .o_reset_from_right(rfr), .o_knee_select(ksel),
		.o_right_reset_drop_mv(drop), .o_reset_generator_enable(gen), .o_right_reset_monitor(mon),
		.o_rolling_shutter(rol), .o_tie_odd_columns(todd), .o_tie_even_columns(tev),
		.o_test_pattern(pat), .o_hsub_mode(hs), .o_vsub_mode(vs));
	srs_ctrl_model i_srs_ctrl_model (.i_clock(i_clock), .o_frame_start(fs), .o_row_clock(rc),
		.o_shutter_start(ss), .o_shutter_stop(sp), .o_ready(rdy), .i_timeout(to));
	initial begin
		forever #50 i_clock = ~i_clock;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Data settles one edge before the strobe so the synchroniser never sees a half word.
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		@(posedge i_clock);
		cfg <= {a, d};
		@(posedge i_clock);
		cfg_wr <= 1'b1;
		repeat (3) @(posedge i_clock);
		cfg_wr <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask
	task automatic wait_on(input int w, input logic v, output int k);
		k = 0;
		while ((w ? to : pv) !== v && k < 1000) begin
			@(posedge i_clock);
			k++;
		end
	endtask
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		n_last <= n_last + (ll === 1'b1);
		n_rs <= n_rs + (xps === 1'b1);
		n_xs <= n_xs + (rps === 1'b1);
		if (cyc == 30000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge i_clock);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clock);
		chk(expo, 12'hc00, "exposure");
		chk(12'({rol, gen, mon}), 12'h003, "reset state");
		for (int k = 0; k < 4; k++) begin
			wr(4'h0, {2'b01, k[1:0], 8'h00});
			chk(drop, dmv[k], "drop");
			chk(12'({rfr, ksel}), 12'(4 + k), "knee");
		end
		wr(4'h0, 12'h800);
		chk(12'({rfr, gen, mon}), 12'h000, "external");
		$display("test reset voltage done");
		foreach (cv[i]) begin
			wr(4'h7, {4'h0, cv[i]});
			b = (cv[i] == 8'h01 || cv[i] == 8'h02) ? 1 : (cv[i] == 8'h09) ? 2 : 0;
			chk(12'({pat, vs, hs, todd, tev}), 12'({b[1:0], cv[i]}), "core");
		end
		$display("test core done");
		// Row clock granularity of eight stretches blanking to 280 cycles.
		wr(4'h0, 12'h010);
		wr(4'h1, 12'h027);
		wr(4'h4, 12'h005);
		i_srs_ctrl_model.stall <= 1'b1;
		i_srs_ctrl_model.pulse(1, 3);
		wait_on(0, 1'b1, n);
		chk(12'(n >= 281 && n <= 287), 12'h001, "blanking");
		repeat (80) @(posedge i_clock);
		chk(12'({pv, ov}), 12'h003, "stalled full");
		i_srs_ctrl_model.stall <= 1'b0;
		cnt = 0;
		repeat (120) begin
			@(posedge i_clock);
			if (ov === 1'b1 && rdy === 1'b1) begin
				chk({1'b0, pix.column}, 12'(5 + cnt), "column");
				chk({1'b0, pix.row}, 12'h000, "row");
				cnt++;
			end
		end
		chk(12'(cnt), 12'h028, "pushes");
		chk(12'({pv, ov}), 12'h000, "row end");
		$display("test readout done");
		wr(4'h0, 12'h000);
		wr(4'h1, 12'h003);
		wr(4'h2, 12'h003);
		b = n_last;
		i_srs_ctrl_model.pulse(0, 3);
		for (int r = 0; r < 3; r++) begin
			i_srs_ctrl_model.pulse(1, 2);
			repeat (200) @(posedge i_clock);
			chk(12'(n_last - b), 12'(r == 2), "last line");
		end
		$display("test lines done");
		wr(4'h0, 12'h001);
		wr(4'h5, 12'h007);
		wr(4'h6, 12'h007);
		wr(4'h3, 12'h002);
		chk(12'(rol), 12'h001, "rolling");
		chk(expo, 12'h001, "exposure");
		b = n_rs;
		for (int f = 0; f < 2; f++) begin
			i_srs_ctrl_model.pulse(0, 3);
			repeat (6) @(posedge i_clock);
			chk({1'b0, rptr}, 12'h007, "read load");
			chk(12'(n_xs), 12'(f + 1), "read sync");
			for (int r = 0; r < 2; r++) begin
				i_srs_ctrl_model.pulse(1, 2);
				repeat (200) @(posedge i_clock);
				chk({1'b0, rptr}, 12'(8 + r), "advance");
				chk(12'(n_rs - b), 12'(f + r), "reset sync");
			end
			chk({1'b0, xptr}, 12'h007, "reset load");
		end
		$display("test rolling done");
		// Shutter granularity of 64 cycles, so ten steps take 640 cycles.
		wr(4'h0, 12'h040);
		wr(4'h3, 12'h00a);
		i_srs_ctrl_model.pulse(2, 2);
		wait_on(1, 1'b1, n);
		chk(12'(n >= 636 && n <= 652), 12'h001, "timeout");
		wait_on(1, 1'b0, n);
		chk(12'(n), 12'h040, "timeout width");
		i_srs_ctrl_model.pulse(2, 2);
		repeat (100) @(posedge i_clock);
		i_srs_ctrl_model.abort <= 1'b1;
		repeat (5) @(posedge i_clock);
		i_srs_ctrl_model.abort <= 1'b0;
		wait_on(1, 1'b1, n);
		chk(12'(n), 12'h3e8, "abort");
		$display("test shutter done");
		tally_and_finish();
	end
endmodule // srs_sequencer_tb
